//--- design/cip_pkg.sv
// Constants, flag layout and states for the interrupt and power-down block
package cip_pkg;
  localparam int FLAG_W = 18;
  localparam int F_VEC = 0;
  localparam int F_WLIF = 8;
  localparam int F_EPIF = 9;
  localparam int F_BOIF = 10;
  localparam int F_RMLIF = 11;
  localparam int F_WUIF = 12;
  localparam int F_WDIF = 13;
  localparam int F_AAIF = 14;
  localparam int F_GMIF = 15;
  localparam int F_TCOF = 16;
  localparam int F_MTOF = 17;
  localparam int M_LINE0_ENABLE = 0;
  localparam int M_LINE1_ENABLE = 1;
  localparam int M_GIL = 2;
  localparam int M_WARNING_LEVEL_MASK = 9;
  localparam int M_ERROR_PASSIVE_MASK = 10;
  localparam int M_BUS_OFF_MASK = 11;
  localparam int M_WAKEUP_MASK = 12;
  localparam int M_WRITE_DENIED_MASK = 13;
  localparam int M_ABORT_IRQ_MASK = 14;
  localparam int M_RMLIM = 15;
  localparam int M_MTOM = 16;
  localparam int M_TCOM = 17;
  // System flag index 0..5: timestamp, write-denied, wakeup, bus-off, passive, warning
  localparam int SYS_N = 6;
  localparam int SYS_WU = 2;
  localparam int SYS_POS [SYS_N] = '{F_TCOF, F_WDIF, F_WUIF, F_BOIF, F_EPIF, F_WLIF};
  localparam int SYS_MPOS [SYS_N] = '{M_TCOM, M_WRITE_DENIED_MASK, M_WAKEUP_MASK, M_BUS_OFF_MASK, M_ERROR_PASSIVE_MASK, M_WARNING_LEVEL_MASK};
  localparam int MODULE_CLK_BIT = 14;
  localparam logic [15:0] PCLK_CTRL_RESET = 16'h0000;
  localparam logic [31:0] ES_PD_READ = 32'h00000008;
  localparam logic [31:0] PD_READ_OTHER = 32'h00000000;
  localparam int IDLE_BITS = 11;
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {
    PD_RUN = 2'b00,
    PD_DRAIN = 2'b01,
    PD_SLEEP = 2'b10,
    PD_WAKE = 2'b11
  } cip_pd_e;
endpackage

//--- design/cip_mbx_vector.sv
// Highest-numbered pending mailbox finder
module cip_mbx_vector import cip_pkg::*; #(
  parameter int MBX_NUM = 32
) (
  input wire logic [MBX_NUM-1:0] req,
  output logic [4:0] vector
);
  always_comb begin
    vector = 5'h00;
    for (int i = 0; i < MBX_NUM; i++) begin
      if (req[i]) begin
        vector = 5'(i);
      end
    end
  end
endmodule

//--- design/cip_bus_idle.sv
// Receive pin synchroniser, bit-rate divider and recessive-run counter
module cip_bus_idle import cip_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic busRxPin,
  input wire logic restart,
  output logic activity,
  output logic idleDone
);
  localparam int DW = $clog2(BIT_CYC + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(BIT_CYC - 1);
  localparam logic [3:0] RUN_LEN = 4'(IDLE_BITS);
  logic rxMeta;
  logic rxSync;
  logic [DW-1:0] divCnt;
  logic [3:0] runCnt;
  logic bitTick;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= busRxPin;
      rxSync <= rxMeta;
    end
  end

  assign bitTick = (divCnt == DIV_LAST);
  assign activity = ~rxSync;
  assign idleDone = (runCnt == RUN_LEN);

  always_ff @(posedge core_clk) begin
    if (sys_rst || restart || bitTick) begin
      divCnt <= '0;
    end else begin
      divCnt <= divCnt + 1'b1;
    end
  end

  // Any dominant sample restarts the recessive run
  always_ff @(posedge core_clk) begin
    if (sys_rst || restart) begin
      runCnt <= 4'h0;
    end else if (bitTick) begin
      if (!rxSync) begin
        runCnt <= 4'h0;
      end else if (runCnt != RUN_LEN) begin
        runCnt <= runCnt + 4'h1;
      end
    end
  end

  run_needs_ticks_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(idleDone) |-> $past(bitTick) && $past(rxSync))
    else $error("idle reached without a recessive bit sample");
endmodule

//--- design/can_irq_and_powerdown.sv
// Interrupt flag routing, clearing and local power-down control
module can_irq_and_powerdown import cip_pkg::*; #(
  parameter int MBX_NUM = 32,
  parameter int BIT_CYC = BIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [MBX_NUM-1:0] mailboxEnable,
  input wire logic [MBX_NUM-1:0] mailboxDirRx,
  input wire logic [MBX_NUM-1:0] txAckBits,
  input wire logic [MBX_NUM-1:0] rxPendingBits,
  input wire logic [MBX_NUM-1:0] abortAckBits,
  input wire logic [MBX_NUM-1:0] rxLostBits,
  input wire logic [MBX_NUM-1:0] mailboxTimeoutStatus,
  input wire logic [MBX_NUM-1:0] mailboxLevel,
  input wire logic [MBX_NUM-1:0] mailboxMask,
  input wire logic [FLAG_W-1:0] globalIrqMask,
  input wire logic tsOverflowEvt,
  input wire logic writeDeniedEvt,
  input wire logic busOffEvt,
  input wire logic errPassiveEvt,
  input wire logic warnLevelEvt,
  input wire logic flagWrite0,
  input wire logic flagWrite1,
  input wire logic [FLAG_W-1:0] flagWriteData,
  input wire logic pdrSet,
  input wire logic pdrClear,
  input wire logic wakeOnBusActivity,
  input wire logic txInProgress,
  input wire logic [15:0] periphClkCtrl,
  input wire logic busRxPin,
  input wire logic readIsErrorStatus,
  input wire logic [31:0] normalReadData,
  output logic [FLAG_W-1:0] irqFlags0,
  output logic [FLAG_W-1:0] irqFlags1,
  output logic irqLine0,
  output logic irqLine1,
  output logic powerdownRequest,
  output logic powerdownAck,
  output logic moduleClkEnable,
  output logic busActive,
  output logic [31:0] readData
);
  cip_pd_e pdState;
  cip_pd_e next_pdState;
  logic global_level_select;
  logic [SYS_N-1:0] sysEvt;
  logic [SYS_N-1:0] sysFlag0;
  logic [SYS_N-1:0] sysFlag1;
  logic [MBX_NUM-1:0] doneAll;
  logic [MBX_NUM-1:0] doneReq0;
  logic [MBX_NUM-1:0] doneReq1;
  logic [MBX_NUM-1:0] toReq0;
  logic [MBX_NUM-1:0] toReq1;
  logic [4:0] vecNext0;
  logic [4:0] vecNext1;
  logic [4:0] vec0;
  logic [4:0] vec1;
  logic gm0;
  logic gm1;
  logic mto0;
  logic mto1;
  logic aaNow;
  logic rmlNow;
  logic aa0;
  logic aa1;
  logic rml0;
  logic rml1;
  logic [FLAG_W-1:0] prevFlags0;
  logic [FLAG_W-1:0] prevFlags1;
  logic [FLAG_W-1:0] flagMaskVec;
  logic fell0;
  logic fell1;
  logic busWake;
  logic idleDone;
  logic wakeDone;

  assign global_level_select = globalIrqMask[M_GIL];
  assign sysEvt = {warnLevelEvt, errPassiveEvt, busOffEvt, wakeDone, writeDeniedEvt,
                   tsOverflowEvt};

  // Mailbox sources are levels from the mailbox status bits
  assign doneAll = mailboxEnable & mailboxMask &
                   ((mailboxDirRx & rxPendingBits) | (~mailboxDirRx & txAckBits));
  assign doneReq0 = doneAll & ~mailboxLevel;
  assign doneReq1 = doneAll & mailboxLevel;
  assign toReq0 = mailboxEnable & mailboxTimeoutStatus & ~mailboxLevel;
  assign toReq1 = mailboxEnable & mailboxTimeoutStatus & mailboxLevel;
  assign aaNow = |(abortAckBits & mailboxEnable);
  assign rmlNow = |(rxLostBits & rxPendingBits & mailboxEnable);

  cip_mbx_vector #(.MBX_NUM(MBX_NUM)) u_vec0 (
    .req(doneReq0),
    .vector(vecNext0)
  );

  cip_mbx_vector #(.MBX_NUM(MBX_NUM)) u_vec1 (
    .req(doneReq1),
    .vector(vecNext1)
  );

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gm0 <= 1'b0;
      gm1 <= 1'b0;
      vec0 <= 5'h00;
      vec1 <= 5'h00;
      mto0 <= 1'b0;
      mto1 <= 1'b0;
    end else begin
      gm0 <= |doneReq0;
      gm1 <= |doneReq1;
      vec0 <= vecNext0;
      vec1 <= vecNext1;
      mto0 <= |toReq0;
      mto1 <= |toReq1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aa0 <= 1'b0;
      aa1 <= 1'b0;
      rml0 <= 1'b0;
      rml1 <= 1'b0;
    end else begin
      aa0 <= aaNow & ~global_level_select;
      aa1 <= aaNow & global_level_select;
      rml0 <= rmlNow & ~global_level_select;
      rml1 <= rmlNow & global_level_select;
    end
  end

  // Sticky system flags: a set in the clearing cycle wins
  for (genvar gi = 0; gi < SYS_N; gi++) begin : g_sys
    always_ff @(posedge core_clk) begin
      if (sys_rst) begin
        sysFlag0[gi] <= 1'b0;
        sysFlag1[gi] <= 1'b0;
      end else begin
        sysFlag0[gi] <= (sysEvt[gi] & ~global_level_select) |
                        (sysFlag0[gi] & ~(flagWrite0 & flagWriteData[SYS_POS[gi]]));
        sysFlag1[gi] <= (sysEvt[gi] & global_level_select) |
                        (sysFlag1[gi] & ~(flagWrite1 & flagWriteData[SYS_POS[gi]]));
      end
    end
  end

  function automatic logic [FLAG_W-1:0] packFlags(input logic [SYS_N-1:0] sys,
      input logic mto, input logic gm, input logic aa, input logic rx_lost_bits,
      input logic [4:0] vec);
    logic [FLAG_W-1:0] f;
    f = '0;
    for (int k = 0; k < SYS_N; k++) begin
      f[SYS_POS[k]] = sys[k];
    end
    f[F_MTOF] = mto;
    f[F_GMIF] = gm;
    f[F_AAIF] = aa;
    f[F_RMLIF] = rx_lost_bits;
    f[F_VEC +: 5] = gm ? vec : 5'h00;
    return f;
  endfunction

  assign irqFlags0 = packFlags(sysFlag0, mto0, gm0, aa0, rml0, vec0);
  assign irqFlags1 = packFlags(sysFlag1, mto1, gm1, aa1, rml1, vec1);

  // Flag bits that may drive a line; mailbox done is gated per mailbox already
  always_comb begin
    flagMaskVec = '0;
    for (int k = 0; k < SYS_N; k++) begin
      flagMaskVec[SYS_POS[k]] = globalIrqMask[SYS_MPOS[k]];
    end
    flagMaskVec[F_AAIF] = globalIrqMask[M_ABORT_IRQ_MASK];
    flagMaskVec[F_RMLIF] = globalIrqMask[M_RMLIM];
    flagMaskVec[F_MTOF] = globalIrqMask[M_MTOM];
    flagMaskVec[F_GMIF] = 1'b1;
  end

  // A cleared flag drops the line one cycle so leftovers raise a fresh edge
  assign fell0 = |(prevFlags0 & ~irqFlags0 & ~FLAG_W'(32'h1f));
  assign fell1 = |(prevFlags1 & ~irqFlags1 & ~FLAG_W'(32'h1f));

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prevFlags0 <= '0;
      prevFlags1 <= '0;
      irqLine0 <= 1'b0;
      irqLine1 <= 1'b0;
    end else begin
      prevFlags0 <= irqFlags0;
      prevFlags1 <= irqFlags1;
      irqLine0 <= globalIrqMask[M_LINE0_ENABLE] & (|(irqFlags0 & flagMaskVec)) & ~fell0;
      irqLine1 <= globalIrqMask[M_LINE1_ENABLE] & (|(irqFlags1 & flagMaskVec)) & ~fell1;
    end
  end

  cip_bus_idle #(.BIT_CYC(BIT_CYC)) u_idle (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .busRxPin(busRxPin),
    .restart(pdState != PD_WAKE),
    .activity(busWake),
    .idleDone(idleDone)
  );

  assign wakeDone = (pdState == PD_WAKE) && idleDone;

  always_comb begin
    next_pdState = pdState;
    case (pdState)
      PD_RUN: begin
        if (powerdownRequest) begin
          next_pdState = PD_DRAIN;
        end
      end
      PD_DRAIN: begin
        if (!powerdownRequest) begin
          next_pdState = PD_RUN;
        end else if (!txInProgress) begin
          next_pdState = PD_SLEEP;
        end
      end
      PD_SLEEP: begin
        if (!powerdownRequest || (wakeOnBusActivity && busWake)) begin
          next_pdState = PD_WAKE;
        end
      end
      PD_WAKE: begin
        if (idleDone) begin
          next_pdState = PD_RUN;
        end
      end
      default: begin
        next_pdState = PD_RUN;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pdState <= PD_RUN;
    end else begin
      pdState <= next_pdState;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      powerdownRequest <= 1'b0;
    end else if (wakeDone) begin
      powerdownRequest <= 1'b0;
    end else if (pdrSet) begin
      powerdownRequest <= 1'b1;
    end else if (pdrClear) begin
      powerdownRequest <= 1'b0;
    end
  end

  // Acknowledge and wakeup live on this always-on logic; only the module clock enable is gated
  assign powerdownAck = (pdState == PD_SLEEP);
  assign moduleClkEnable = periphClkCtrl[MODULE_CLK_BIT] & (pdState != PD_SLEEP);
  assign busActive = (pdState == PD_RUN) || (pdState == PD_DRAIN);

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      readData <= 32'h00000000;
    end else if (pdState == PD_SLEEP) begin
      readData <= readIsErrorStatus ? ES_PD_READ : PD_READ_OTHER;
    end else begin
      readData <= normalReadData;
    end
  end

  route_global_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    writeDeniedEvt && global_level_select |=> irqFlags1[F_WDIF] && !$rose(irqFlags0[F_WDIF]))
    else $error("write-denied event not routed to register 1");

  w1c_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    flagWrite0 && flagWriteData[F_BOIF] && !(busOffEvt && !global_level_select) |=> !irqFlags0[F_BOIF])
    else $error("bus-off flag survived a write of one");

  write_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    irqFlags0[F_WLIF] && !(flagWrite0 && flagWriteData[F_WLIF]) |=> irqFlags0[F_WLIF])
    else $error("warning flag lost without a clearing write");

  timeout_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    flagWrite0 && flagWriteData[F_MTOF] && (|toReq0) |=> irqFlags0[F_MTOF])
    else $error("timeout flag cleared by a direct write");

  vector_match_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    irqFlags1[F_GMIF] |-> $past(|doneReq1) &&
      ($past(doneReq1) >> irqFlags1[4:0]) == MBX_NUM'(1))
    else $error("vector is not the highest pending mailbox");

  line_release_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    irqLine0 |-> $past(globalIrqMask[M_LINE0_ENABLE]) && $past(|(irqFlags0 & flagMaskVec)))
    else $error("line 0 raised without an unmasked flag");

  ack_after_tx_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(powerdownAck) |-> $past(!txInProgress) && $past(powerdownRequest))
    else $error("acknowledge while a transmission ran");

  sleep_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    powerdownAck ##1 powerdownAck |-> readData == ($past(readIsErrorStatus) ? ES_PD_READ : 32'h0))
    else $error("wrong read value in power-down");

  wake_exit_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    wakeDone |=> !powerdownRequest && !powerdownAck && busActive && irqFlags0[F_WUIF] | irqFlags1[F_WUIF])
    else $error("wake exit left request set or no wakeup flag");

  wake_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(busActive) && $past(pdState == PD_WAKE) |-> $past(idleDone))
    else $error("bus active before the recessive run");
endmodule

//--- test/cip_bus_node.sv
// Remote node that sends frames of random bits on the receive pin
module cip_bus_node import cip_pkg::*; #(
  parameter int BIT_CYC = 4
) (
  input wire logic core_clk,
  input wire logic sendFrame,
  input wire logic [31:0] seed,
  output logic busRxPin,
  output logic frameBusy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic frameBits [$];
  initial begin
    busRxPin = 1'b1;
    frameBusy = 1'b0;
  end
  // Dominant first and last bit, bus left recessive between frames
  always @(posedge core_clk) begin
    if (sendFrame && !frameBusy) begin
      frameBusy <= 1'b1;
      frameBits = {1'b0};
      // Every fifth bit dominant keeps recessive runs well short of the idle count
      for (int i = 1; i < 15; i++) frameBits.push_back(seed[i] && (i % 5 != 0));
      frameBits.push_back(1'b0);
      while (frameBits.size() > 0) begin
        busRxPin <= frameBits.pop_front();
        repeat (BIT_CYC) @(posedge core_clk);
      end
      busRxPin <= 1'b1;
      frameBusy <= 1'b0;
    end
  end
endmodule

//--- test/can_irq_and_powerdown_bench.sv
// Self-checking bench for interrupt flags and local power-down
module can_irq_and_powerdown_bench import cip_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BC = 4;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] mailboxEnable = '0, mailboxDirRx = '0, txAckBits = '0, rxPendingBits = '0;
  logic [31:0] abortAckBits = '0, rxLostBits = '0, mailboxTimeoutStatus = '0;
  logic [31:0] mailboxLevel = '0, mailboxMask = '0, normalReadData = '0;
  logic [FLAG_W-1:0] globalIrqMask = '0, flagWriteData = '0;
  logic [4:0] evt = '0;
  logic flagWrite0 = 1'b0, flagWrite1 = 1'b0, pdrSet = 1'b0, pdrClear = 1'b0;
  logic wakeOnBusActivity = 1'b0, txInProgress = 1'b0, readIsErrorStatus = 1'b0;
  logic sendFrame = 1'b0;
  logic [15:0] periphClkCtrl = '0;
  logic busRxPin, frameBusy, irqLine0, irqLine1, powerdownRequest, powerdownAck;
  logic moduleClkEnable, busActive;
  logic [FLAG_W-1:0] irqFlags0, irqFlags1;
  logic [31:0] readData;
  logic [31:0] r = 32'h20fa1f4b;
  logic [FLAG_W-1:0] expF [2] = '{'0, '0};
  int pos [5] = '{F_TCOF, F_WDIF, F_BOIF, F_EPIF, F_WLIF};
  int errorCnt = 0, samplesChecked = 0, cycles = 0, a, b, hi, lo, n, bad;

  can_irq_and_powerdown #(.MBX_NUM(32), .BIT_CYC(BC)) DUT (.core_clk, .sys_rst,
    .mailboxEnable, .mailboxDirRx, .txAckBits, .rxPendingBits, .abortAckBits, .rxLostBits,
    .mailboxTimeoutStatus, .mailboxLevel, .mailboxMask, .globalIrqMask,
    .tsOverflowEvt(evt[0]), .writeDeniedEvt(evt[1]), .busOffEvt(evt[2]),
    .errPassiveEvt(evt[3]), .warnLevelEvt(evt[4]), .flagWrite0, .flagWrite1,
    .flagWriteData, .pdrSet, .pdrClear, .wakeOnBusActivity, .txInProgress, .periphClkCtrl,
    .busRxPin, .readIsErrorStatus, .normalReadData, .irqFlags0, .irqFlags1, .irqLine0,
    .irqLine1, .powerdownRequest, .powerdownAck, .moduleClkEnable, .busActive, .readData);
  cip_bus_node #(.BIT_CYC(BC)) node (.core_clk, .sendFrame, .seed(r), .busRxPin, .frameBusy);

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errorCnt++;
      endSim();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic endSim();
    $display("Checks %0d, errors %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic cmp1(input string nm, input logic e, input logic g);
    #1 samplesChecked++;
    if (e !== g) begin
      errorCnt++;
      $display("Error %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic cmp18(input string nm, input logic [FLAG_W-1:0] e, input logic [FLAG_W-1:0] g);
    #1 samplesChecked++;
    if (e !== g) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    #1 samplesChecked++;
    if (e !== g) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkF();
    cmp18("flags0", expF[0], irqFlags0);
    cmp18("flags1", expF[1], irqFlags1);
  endtask
  task automatic wr(input int sel, input logic [FLAG_W-1:0] d);
    cyc(1);
    flagWriteData <= d;
    flagWrite0 <= (sel == 0);
    flagWrite1 <= (sel == 1);
    cyc(1);
    flagWrite0 <= 1'b0;
    flagWrite1 <= 1'b0;
    cyc(2);
  endtask
  task automatic pulse(input int which);
    cyc(1);
    if (which == 0) pdrSet <= 1'b1;
    else if (which == 1) pdrClear <= 1'b1;
    else sendFrame <= 1'b1;
    cyc(1);
    pdrSet <= 1'b0;
    pdrClear <= 1'b0;
    sendFrame <= 1'b0;
    @(negedge core_clk);
  endtask
  task automatic waitActive();
    n = 0;
    while (busActive !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  initial begin
    cyc(4);
    cmp1("clock enable", 1'b0, moduleClkEnable);
    sys_rst <= 1'b0;
    cyc(2);
    chkF();
    cmp1("bus active", 1'b1, busActive);
    for (int g = 0; g < 2; g++) begin
      globalIrqMask <= g ? 18'h3fe07 : 18'h3fe03;
      for (int e = 0; e < 5; e++) begin
        cyc(1);
        evt[e] <= 1'b1;
        cyc(1);
        evt <= '0;
        expF[g][pos[e]] = 1'b1;
        cyc(2);
        chkF();
        cmp1("own line", 1'b1, g ? irqLine1 : irqLine0);
        cmp1("other line", 1'b0, g ? irqLine0 : irqLine1);
        wr(g, ~(18'h1 << pos[e]));
        chkF();
        wr(g, 18'h1 << pos[e]);
        expF[g][pos[e]] = 1'b0;
        cyc(1);
        chkF();
        cmp1("line released", 1'b0, g ? irqLine1 : irqLine0);
      end
    end
    globalIrqMask <= 18'h3fe03;
    evt <= 5'b00011;
    cyc(1);
    evt <= '0;
    wr(0, 18'h1 << F_WDIF);
    expF[0][F_TCOF] = 1'b1;
    chkF();
    cmp1("re-raised line", 1'b1, irqLine0);
    wr(0, 18'h1 << F_TCOF);
    expF[0] = '0;
    globalIrqMask <= 18'h00003;
    evt[2] <= 1'b1;
    cyc(1);
    evt <= '0;
    cyc(2);
    cmp18("masked flag", 18'h1 << F_BOIF, irqFlags0);
    cmp1("masked line", 1'b0, irqLine0);
    wr(0, 18'h1 << F_BOIF);
    r = lfsr(r);
    a = r[4:0];
    b = r[9:5];
    if (a == b) b = a ^ 1;
    hi = a > b ? a : b;
    lo = a > b ? b : a;
    globalIrqMask <= 18'h3fe03;
    mailboxEnable <= '1;
    mailboxMask <= '1;
    txAckBits <= (32'h1 << a) | (32'h1 << b);
    cyc(3);
    expF[0] = 18'h08000 | 18'(hi);
    chkF();
    wr(0, 18'h2c81f);
    chkF();
    txAckBits <= 32'h1 << lo;
    cyc(3);
    expF[0] = 18'h08000 | 18'(lo);
    chkF();
    txAckBits <= '0;
    mailboxDirRx <= 32'h1 << lo;
    rxPendingBits <= 32'h1 << lo;
    mailboxLevel <= '1;
    cyc(3);
    expF[0] = '0;
    expF[1] = 18'h08000 | 18'(lo);
    chkF();
    rxPendingBits <= '0;
    mailboxEnable <= ~(32'h1 << a);
    txAckBits <= 32'h1 << a;
    cyc(3);
    expF[1] = '0;
    chkF();
    txAckBits <= '0;
    mailboxEnable <= '1;
    mailboxTimeoutStatus <= 32'h1 << a;
    cyc(3);
    expF[1][F_MTOF] = 1'b1;
    chkF();
    wr(1, 18'h1 << F_MTOF);
    chkF();
    mailboxTimeoutStatus <= '0;
    abortAckBits <= 32'h1 << b;
    cyc(3);
    expF[1] = '0;
    expF[0][F_AAIF] = 1'b1;
    chkF();
    abortAckBits <= '0;
    mailboxDirRx <= 32'h1 << b;
    rxLostBits <= 32'h1 << b;
    rxPendingBits <= 32'h1 << b;
    cyc(3);
    expF[0] = 18'h1 << F_RMLIF;
    expF[1] = 18'h08000 | 18'(b);
    chkF();
    rxPendingBits <= '0;
    cyc(3);
    expF = '{'0, '0};
    chkF();
    rxLostBits <= '0;
    periphClkCtrl <= 16'h4000;
    txInProgress <= 1'b1;
    pulse(0);
    cyc(6);
    cmp1("ack during transfer", 1'b0, powerdownAck);
    cmp1("request", 1'b1, powerdownRequest);
    cmp1("clock during transfer", 1'b1, moduleClkEnable);
    txInProgress <= 1'b0;
    cyc(3);
    cmp1("ack", 1'b1, powerdownAck);
    cmp1("clock gated", 1'b0, moduleClkEnable);
    r = lfsr(r);
    normalReadData <= r;
    readIsErrorStatus <= 1'b1;
    cyc(3);
    cmp32("status read", ES_PD_READ, readData);
    readIsErrorStatus <= 1'b0;
    cyc(3);
    cmp32("other read", PD_READ_OTHER, readData);
    pulse(2);
    while (frameBusy) @(negedge core_clk);
    cyc(2);
    cmp1("ack without wake", 1'b1, powerdownAck);
    pulse(1);
    waitActive();
    cmp1("wake time", 1'b1, n >= 10 * BC && n <= 12 * BC + 6);
    cmp1("request cleared", 1'b0, powerdownRequest);
    cmp1("ack cleared", 1'b0, powerdownAck);
    cyc(2);
    expF[0][F_WUIF] = 1'b1;
    chkF();
    wr(0, 18'h1 << F_WUIF);
    expF[0] = '0;
    cyc(3);
    cmp32("run read", r, readData);
    wakeOnBusActivity <= 1'b1;
    pulse(0);
    cyc(4);
    cmp1("ack before frame", 1'b1, powerdownAck);
    r = lfsr(r);
    pulse(2);
    n = 0;
    bad = 0;
    while (frameBusy) begin
      @(negedge core_clk);
      n++;
      if (n > 4 && busActive !== 1'b0) bad++;
    end
    cmp1("idle during frame", 1'b1, bad == 0);
    waitActive();
    cmp1("bus wake time", 1'b1, n >= 10 * BC && n <= 12 * BC + 6);
    cmp1("ack after bus wake", 1'b0, powerdownAck);
    cyc(2);
    expF[0][F_WUIF] = 1'b1;
    chkF();
    endSim();
  end
endmodule
